// [rtl/spi_count_order.sv]
// Transfer counter, width and bit-order control of a byte-oriented serial slave.
// Assumes an Avalon-MM master with waitrequest and a link clock far slower than mclk.
// Overview of operation
// - Order control: clear MSB first, set LSB
// - Bit mode: upper register is bits 13-11
// - Bit mode: width field is bits 2-0
// - Byte mode: upper register is bits 10-8
// - Byte mode: width codes 1-7, zero means 8
// - Bits 7-3 read zero, fields reset zero
// - Busy stays set during a transfer
// - Count zero flag when counter expires
//
// Implementation choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module spi_count_order (
   // Clock and reset
   input  wire logic                             mclk,
   input  wire logic                             nrst,
   // Avalon-MM register slave
   input  wire logic [spi_cnt_pkg::ADDR_W-1:0]   avs_address,
   input  wire logic                             avs_read,
   input  wire logic                             avs_write,
   input  wire logic [spi_cnt_pkg::DATA_W-1:0]   avs_writedata,
   input  wire logic [3:0]                       avs_byteenable,
   output logic      [spi_cnt_pkg::DATA_W-1:0]   avs_readdata,
   output logic                                  avs_waitrequest,
   // Serial link
   input  wire logic                             sclk,
   input  wire logic                             ss_n,
   input  wire logic                             sdi,
   output logic                                  sdo,
   output logic                                  sdo_oe,
   // Interrupt
   output logic                                  irq
);
   import spi_cnt_pkg::*;

   shift_if sif ();

   logic                  enable_q;     // Block enable
   logic                  low_bit_first_select_q;
   logic                  byte_count_mode_q;
   logic [WORD_W-1:0]     lower_q;      // Counter lower register
   logic [FIELD_W-1:0]    upper_q;      // Counter upper register
   logic [FIELD_W-1:0]    width_q;      // Width register field
   logic [WORD_W-1:0]     tx_q;         // Word to send
   logic [WORD_W-1:0]     rx_q;         // Last word received
   logic [INT_W-1:0]      int_stat_q;   // Sticky event flags
   logic [INT_W-1:0]      int_stat_d;
   logic [INT_W-1:0]      int_mask_q;   // Interrupt enables
   logic                  busy_q;
   logic                  wait_q;
   logic [DATA_W-1:0]     rdata_q;
   logic [DATA_W-1:0]     rdata_d;
   logic                  irq_q;
   logic [CNT_W-1:0]      cnt;          // Counter as one number
   logic [CNT_W-1:0]      cnt_next;
   logic                  run;
   logic                  dec;          // Counter steps this cycle
   logic                  wr_fire;      // Write takes effect this edge
   logic                  wr_lane;      // Low byte lane written
   logic [INT_W-1:0]      events;

   // Assemble the counter from its registers for the current mode
   function automatic logic [CNT_W-1:0] count_of(input logic byte_count_mode,
                                                 input logic [FIELD_W-1:0] up,
                                                 input logic [WORD_W-1:0] lo,
                                                 input logic [FIELD_W-1:0] wd);
      if (byte_count_mode) begin
         count_of = {3'h0, up, lo};
      end else begin
         count_of = {up, lo, wd};
      end
   endfunction

   // Write strobe for one register offset
   function automatic logic wr_to(input logic [ADDR_W-1:0] off);
      wr_to = wr_fire && wr_lane && (avs_address == off);
   endfunction

   assign cnt      = count_of(byte_count_mode_q, upper_q, lower_q, width_q);
   assign cnt_next = cnt - CNT_ONE;
   assign run      = enable_q && (cnt != CNT_ZERO);
   // Bit mode counts each bit, byte mode each finished word
   assign dec      = run && (byte_count_mode_q ? sif.word_done : sif.bit_done);
   assign wr_fire  = avs_write && !wait_q;
   assign wr_lane  = avs_byteenable[0];

   // Feed the shifter
   assign sif.run       = run;
   assign sif.lsb_first = low_bit_first_select_q;
   assign sif.tx_word   = tx_q;

   always_comb begin
      if (byte_count_mode_q && (width_q != WIDTH_CODE_8)) begin
         sif.word_len = {1'b0, width_q};
      end else begin
         sif.word_len = FULL_WORD_LEN;
      end
   end

   spi_bit_shifter u_shifter (
      .mclk (mclk),
      .nrst (nrst),
      .sclk (sclk),
      .ss_n (ss_n),
      .sdi  (sdi),
      .sif  (sif.shift)
   );

   // Bus handshake: one wait cycle, then a single low cycle per request
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= !((avs_read || avs_write) && wait_q);
      end
   end

   // order control resets clear
   // Control register; changes mid-word take effect at once
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         enable_q               <= 1'b0;
         low_bit_first_select_q <= 1'b0;
         byte_count_mode_q      <= 1'b0;
      end else if (wr_to(OFF_CONTROL)) begin
         enable_q               <= avs_writedata[CTL_ENABLE];
         low_bit_first_select_q <= avs_writedata[CTL_LOW_FIRST];
         byte_count_mode_q      <= avs_writedata[CTL_BYTE_MODE];
      end
   end

   // fields reset to zero
   // Counter registers; a software write beats a same-cycle count step
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         lower_q <= BYTE_RESET;
      end else if (wr_to(OFF_CNT_LOWER)) begin
         lower_q <= avs_writedata[WORD_W-1:0];
      end else if (dec) begin
         lower_q <= byte_count_mode_q ? cnt_next[7:0] : cnt_next[10:3];
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         upper_q <= FIELD_RESET;
      end else if (wr_to(OFF_CNT_UPPER)) begin
         upper_q <= avs_writedata[FIELD_W-1:0];
      end else if (dec) begin
         upper_q <= byte_count_mode_q ? cnt_next[10:8] : cnt_next[13:11];
      end
   end

   // In byte mode the width stays put as the word length
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         width_q <= FIELD_RESET;
      end else if (wr_to(OFF_WIDTH)) begin
         width_q <= avs_writedata[FIELD_W-1:0];
      end else if (dec && !byte_count_mode_q) begin
         width_q <= cnt_next[FIELD_W-1:0];
      end
   end

   // Transmit and receive words
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tx_q <= BYTE_RESET;
         rx_q <= BYTE_RESET;
      end else begin
         if (wr_to(OFF_DATA)) begin
            tx_q <= avs_writedata[WORD_W-1:0];
         end
         if (sif.word_done) begin
            rx_q <= sif.rx_word;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= run;
      end
   end

   always_comb begin
      events               = INT_RESET;
      events[INT_CNT_ZERO] = dec && (cnt == CNT_ONE);
      events[INT_RX_WORD]  = sif.word_done;
      int_stat_d           = int_stat_q;
      if (wr_to(OFF_INT_STAT)) begin
         int_stat_d = int_stat_q & ~avs_writedata[INT_W-1:0];
      end
      // Set beats a same-cycle clear so no event is lost
      int_stat_d = int_stat_d | events;
   end

   // Sticky flags, mask and level interrupt
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         int_stat_q <= INT_RESET;
         int_mask_q <= INT_RESET;
         irq_q      <= 1'b0;
      end else begin
         int_stat_q <= int_stat_d;
         if (wr_to(OFF_INT_MASK)) begin
            int_mask_q <= avs_writedata[INT_W-1:0];
         end
         irq_q <= |(int_stat_d & int_mask_q);
      end
   end

   // upper bits read zero
   // Read mux; unmapped offsets read zero
   always_comb begin
      rdata_d = '0;
      unique case (avs_address)
         OFF_CONTROL: begin
            rdata_d[CTL_ENABLE]    = enable_q;
            rdata_d[CTL_LOW_FIRST] = low_bit_first_select_q;
            rdata_d[CTL_BYTE_MODE] = byte_count_mode_q;
         end
         OFF_STATUS:    rdata_d[STAT_BUSY]        = busy_q;
         OFF_CNT_LOWER: rdata_d[WORD_W-1:0]       = lower_q;
         OFF_CNT_UPPER: rdata_d[FIELD_W-1:0]      = upper_q;
         OFF_WIDTH:     rdata_d[FIELD_W-1:0]      = width_q;
         OFF_DATA:      rdata_d[WORD_W-1:0]       = rx_q;
         OFF_INT_STAT:  rdata_d[INT_W-1:0]        = int_stat_q;
         OFF_INT_MASK:  rdata_d[INT_W-1:0]        = int_mask_q;
         default:       rdata_d                   = '0;
      endcase
   end

   // Read data captured in the wait cycle, stands when waitrequest drops
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdata_q <= '0;
      end else if (avs_read && wait_q) begin
         rdata_q <= rdata_d;
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign irq             = irq_q;
   assign sdo             = sif.sdo;
   assign sdo_oe          = sif.sdo_oe;
endmodule
`default_nettype wire

// [pkg/spi_cnt_pkg.sv]
// Constants shared by the transfer-counter block and its bit shifter.
// Assumes a 32-bit Avalon-MM slave with byte addresses, registers in the low byte.
`default_nettype none
package spi_cnt_pkg;
   // Bus geometry
   localparam int ADDR_W = 5;
   localparam int DATA_W = 32;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CONTROL   = 5'h00;
   localparam logic [ADDR_W-1:0] OFF_STATUS    = 5'h04;
   localparam logic [ADDR_W-1:0] OFF_CNT_LOWER = 5'h08;
   localparam logic [ADDR_W-1:0] OFF_CNT_UPPER = 5'h0C;
   localparam logic [ADDR_W-1:0] OFF_WIDTH     = 5'h10;
   localparam logic [ADDR_W-1:0] OFF_DATA      = 5'h14;
   localparam logic [ADDR_W-1:0] OFF_INT_STAT  = 5'h18;
   localparam logic [ADDR_W-1:0] OFF_INT_MASK  = 5'h1C;
   // Control register fields
   localparam int CTL_ENABLE    = 0;
   localparam int CTL_LOW_FIRST = 1;
   localparam int CTL_BYTE_MODE = 2;
   // Status and interrupt fields
   localparam int STAT_BUSY    = 0;
   localparam int INT_CNT_ZERO = 0;
   localparam int INT_RX_WORD  = 1;
   localparam int INT_W        = 2;
   // Counter geometry
   localparam int CNT_W   = 14;
   localparam int FIELD_W = 3;
   localparam int WORD_W  = 8;
   localparam int LEN_W   = 4;
   localparam logic [LEN_W-1:0]   FULL_WORD_LEN = 4'h8;
   localparam logic [FIELD_W-1:0] WIDTH_CODE_8  = 3'h0;
   // Reset values and counter step constants
   localparam logic [FIELD_W-1:0] FIELD_RESET = 3'h0;
   localparam logic [WORD_W-1:0]  BYTE_RESET  = 8'h00;
   localparam logic [INT_W-1:0]   INT_RESET   = 2'h0;
   localparam logic [CNT_W-1:0]   CNT_ONE     = 14'h0001;
   localparam logic [CNT_W-1:0]   CNT_ZERO    = 14'h0000;
endpackage
`default_nettype wire

// [pkg/shift_if.sv]
// Link between the register/counter logic and the serial bit shifter.
// Both ends run on mclk; nothing here crosses a clock domain.
`timescale 1ns/100ps
`default_nettype none
interface shift_if;
   import spi_cnt_pkg::*;
   logic              run;        // Counter nonzero and block enabled
   logic              lsb_first;  // Low bit leaves first
   logic [LEN_W-1:0]  word_len;   // Bits per word, 1 to 8
   logic [WORD_W-1:0] tx_word;    // Word to shift out, right aligned
   logic              bit_done;   // One-cycle pulse per sampled bit
   logic              word_done;  // One-cycle pulse per finished word
   logic [WORD_W-1:0] rx_word;    // Last received word, right aligned
   logic              sdo;        // Serial data out
   logic              sdo_oe;     // Drive enable for serial data out
   modport ctrl  (output run, lsb_first, word_len, tx_word,
                  input bit_done, word_done, rx_word, sdo, sdo_oe);
   modport shift (input run, lsb_first, word_len, tx_word,
                  output bit_done, word_done, rx_word, sdo, sdo_oe);
endinterface
`default_nettype wire

// [rtl/spi_bit_shifter.sv]
// Slave-side bit shifter: samples the link pins and moves one word at a time.
// Assumes link clock idles low, data sampled on rising and driven after falling edge.
`timescale 1ns/100ps
`default_nettype none
module spi_bit_shifter (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic nrst,
   // Link pins, asynchronous to mclk
   input  wire logic sclk,
   input  wire logic ss_n,
   input  wire logic sdi,
   // Control side
   shift_if.shift    sif
);
   import spi_cnt_pkg::*;

   logic [2:0]        sclk_q;    // Two sync stages plus edge history
   logic [1:0]        ss_n_q;    // Two sync stages
   logic [1:0]        sdi_q;     // Two sync stages
   logic [LEN_W-1:0]  bit_cnt_q; // Bits taken in the current word
   logic [WORD_W-1:0] sh_q;      // Shift register
   logic [WORD_W-1:0] sh_d;      // Shift register after one more bit
   logic [FIELD_W-1:0] top_idx;  // Index of the highest bit of a word
   logic              sel;       // Selected and allowed to run
   logic              rise;      // Link clock rising edge
   logic              fall;      // Link clock falling edge
   logic              last;      // This bit ends the word
   logic              bit_d_q;
   logic              word_d_q;
   logic [WORD_W-1:0] rx_q;
   logic              sdo_q;
   logic              sdo_oe_q;

   // Mask keeping the low len bits of a word
   function automatic logic [WORD_W-1:0] len_mask(input logic [LEN_W-1:0] len);
      len_mask = 8'hFF >> (FULL_WORD_LEN - len);
   endfunction

   // Pin synchronisers; stage 0 feeds only stage 1
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sclk_q <= 3'h0;
         ss_n_q <= 2'h3;
         sdi_q  <= 2'h0;
      end else begin
         sclk_q <= {sclk_q[1:0], sclk};
         ss_n_q <= {ss_n_q[0], ss_n};
         sdi_q  <= {sdi_q[0], sdi};
      end
   end

   assign rise    = sclk_q[1] & ~sclk_q[2];
   assign fall    = ~sclk_q[1] & sclk_q[2];
   assign sel     = ~ss_n_q[1] & sif.run;
   assign top_idx = FIELD_W'(sif.word_len - 4'h1);
   assign last    = (bit_cnt_q == sif.word_len - 4'h1);

   // Next shift value; the order decides where the new bit enters
   always_comb begin
      if (sif.lsb_first) begin
         sh_d          = sh_q >> 1;
         sh_d[top_idx] = sdi_q[1];
      end else begin
         sh_d = {sh_q[WORD_W-2:0], sdi_q[1]};
      end
   end

   // Bit counting and shifting; a deselect drops any partial word
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         bit_cnt_q <= 4'h0;
         sh_q      <= BYTE_RESET;
      end else if (!sel) begin
         bit_cnt_q <= 4'h0;
         sh_q      <= sif.tx_word;
      end else if (rise) begin
         if (last) begin
            bit_cnt_q <= 4'h0;
            sh_q      <= sif.tx_word;
         end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            sh_q      <= sh_d;
         end
      end
   end

   // Event pulses and received word
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         bit_d_q  <= 1'b0;
         word_d_q <= 1'b0;
         rx_q     <= BYTE_RESET;
      end else begin
         bit_d_q  <= sel & rise;
         word_d_q <= sel & rise & last;
         if (sel && rise && last) begin
            rx_q <= sh_d & len_mask(sif.word_len);
         end
      end
   end

   // order picks out bit
   // Output bit changes only on a falling edge or while sel is low, so the master samples a stable level
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sdo_q    <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else begin
         sdo_oe_q <= ~ss_n_q[1];
         if (!sel || fall) begin
            sdo_q <= sif.lsb_first ? sh_q[0] : sh_q[top_idx];
         end
      end
   end

   assign sif.bit_done  = bit_d_q;
   assign sif.word_done = word_d_q;
   assign sif.rx_word   = rx_q;
   assign sif.sdo       = sdo_q;
   assign sif.sdo_oe    = sdo_oe_q;
endmodule
`default_nettype wire

// [bench/spi_count_order_chk.sv]
// Bus, reset, select and interrupt checks for the transfer-counter block.
// Sees only the top ports; the bind at the foot attaches it to every instance.
`timescale 1ns/100ps
`default_nettype none
module spi_count_order_chk (
   // Clock and reset
   input wire logic                           mclk,
   input wire logic                           nrst,
   // Register bus
   input wire logic [spi_cnt_pkg::ADDR_W-1:0] avs_address,
   input wire logic                           avs_read,
   input wire logic                           avs_write,
   input wire logic [spi_cnt_pkg::DATA_W-1:0] avs_writedata,
   input wire logic [3:0]                     avs_byteenable,
   input wire logic [spi_cnt_pkg::DATA_W-1:0] avs_readdata,
   input wire logic                           avs_waitrequest,
   // Link and interrupt
   input wire logic                           sclk,
   input wire logic                           ss_n,
   input wire logic                           sdi,
   input wire logic                           sdo,
   input wire logic                           sdo_oe,
   input wire logic                           irq
);
   import spi_cnt_pkg::*;
   // Read answered in this cycle
   logic rd_ack;
   assign rd_ack = avs_read && !avs_waitrequest;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Reset must be seen here, so this one is never disabled
   a_reset_quiet: assert property (disable iff (1'b0) !nrst
      |=> avs_waitrequest && !irq && !sdo_oe && avs_readdata == '0) else $error("not quiet");
   a_wait_single: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("wait state not one cycle");
   a_wait_release: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait request low too long");
   a_upper_hi_zero: assert property (rd_ack && avs_address == OFF_CNT_UPPER
      |-> avs_readdata[31:3] == '0) else $error("upper register high bits set");
   a_width_hi_zero: assert property (rd_ack && avs_address == OFF_WIDTH
      |-> avs_readdata[31:3] == '0) else $error("width register high bits set");
   a_readdata_hold: assert property (avs_waitrequest && $past(avs_waitrequest)
      |-> $stable(avs_readdata)) else $error("read data moved without a read");
   // The select input passes a synchroniser, hence the run of six
   a_oe_needs_select: assert property (ss_n [*6] |-> !sdo_oe)
      else $error("output driven while deselected");
   a_irq_masked: assert property (avs_write && !avs_waitrequest && avs_byteenable[0]
      && avs_address == OFF_INT_MASK && avs_writedata[1:0] == 2'h0 |-> ##2 !irq [*2])
      else $error("interrupt high with all sources masked");
endmodule
bind spi_count_order spi_count_order_chk spi_count_order_chk_inst (.mclk, .nrst,
   .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
   .avs_waitrequest, .sclk, .ss_n, .sdi, .sdo, .sdo_oe, .irq);
`default_nettype wire

// [bench/spi_link_master.sv]
// Behavioural serial master in mode 0: clock idles low, data sampled on rise.
// Called from the bench; link edges after a select sit 3 ns off the bench clock grid.
`timescale 1ns/100ps
`default_nettype none
module spi_link_master (
   // Link pins toward the slave
   output logic     sclk,
   output logic     ss_n,
   output logic     sdi,
   // Slave answer
   input wire logic sdo,
   input wire logic sdo_oe
);
   initial begin
      sclk = 1'b0;
      ss_n = 1'b1;
      sdi = 1'b0;
   end
   // Select waits a while so the slave can present its first bit
   task automatic select(input logic on);
      // Step off the bench clock edge before moving the select line
      #3;
      ss_n = !on;
      if (on) begin
         #100;
      end else begin
         sdi = ~sdi;
      end
   endtask
   // Clock nb bits of stream tx out, bit 0 first; the clock stands still after
   task automatic bits(input logic [15:0] tx, input int nb, output logic [15:0] rx);
      rx = '0;
      for (int i = 0; i < nb; i++) begin
         sdi = tx[i % 16];
         #40 sclk = 1'b1;
         rx[i % 16] = sdo & sdo_oe;
         #40 sclk = 1'b0;
      end
      #100;
   endtask
endmodule
`default_nettype wire

// [bench/tb_spi_count_order.sv]
// Self-checking bench: registers over Avalon-MM, traffic from a link master model.
// Assumes the one-wait bus timing and register map of the designer's note.
`timescale 1ns/100ps
`default_nettype none
module tb_spi_count_order;
   import spi_cnt_pkg::*;
   logic              mclk, nrst, avs_read, avs_write, avs_waitrequest;
   logic [ADDR_W-1:0] avs_address;
   logic [DATA_W-1:0] avs_writedata, avs_readdata;
   logic [3:0]        avs_byteenable;
   logic              sclk, ss_n, sdi, sdo, sdo_oe, irq;
   logic [15:0]       rx;
   int                fail_count, compares;
   spi_count_order spi_count_order_inst (.mclk, .nrst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .sclk, .ss_n, .sdi,
      .sdo, .sdo_oe, .irq);
   spi_link_master spi_link_master_inst (.sclk, .ss_n, .sdi, .sdo, .sdo_oe);
   // 100 MHz bench clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic summarize();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // One bus cycle; held until waitrequest is sampled low, bounded wait
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      input logic [3:0] be, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= {4{d}};
      avs_byteenable <= be;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 20) begin
         fail_count++;
         summarize();
      end
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hF, q);
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] m,
                     input logic [31:0] e, input string what);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, 4'hF, q);
      chk(q & m, e, what);
   endtask
   task automatic t_regs();
      logic [31:0] q;
      rd(OFF_CNT_UPPER, 32'hFFFFFFFF, 32'h0, "upper reset");
      rd(OFF_WIDTH, 32'hFFFFFFFF, 32'h0, "width reset");
      rd(OFF_CONTROL, 32'h2, 32'h0, "order reset");
      wr(OFF_CNT_UPPER, 8'hFF);
      wr(OFF_WIDTH, 8'hFF);
      rd(OFF_CNT_UPPER, 32'hFFFFFFFF, 32'h7, "upper high bits");
      rd(OFF_WIDTH, 32'hFFFFFFFF, 32'h7, "width high bits");
      bus(1'b1, OFF_CNT_UPPER, 8'h00, 4'hE, q);
      rd(OFF_CNT_UPPER, 32'hFFFFFFFF, 32'h7, "lane off write");
      rd(5'h02, 32'hFFFFFFFF, 32'h0, "unmapped read");
      // Low lane alone is enough for a write to land
      bus(1'b1, OFF_CNT_UPPER, 8'h00, 4'h1, q);
      rd(OFF_CNT_UPPER, 32'hFFFFFFFF, 32'h0, "low lane write");
      wr(OFF_WIDTH, 8'h00);
      $display("test regs done");
   endtask
   // Mid-run reset returns the upper, width and order fields to zero; read data is zero beforehand
   task automatic t_reset();
      wr(OFF_CNT_UPPER, 8'h05);
      wr(OFF_WIDTH, 8'h06);
      wr(OFF_CONTROL, 8'h02);
      rd(5'h02, 32'hFFFFFFFF, 32'h0, "read zero before reset");
      @(posedge mclk);
      nrst <= 1'b0;
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      rd(OFF_CNT_UPPER, 32'hFFFFFFFF, 32'h0, "upper after reset");
      rd(OFF_WIDTH, 32'hFFFFFFFF, 32'h0, "width after reset");
      rd(OFF_CONTROL, 32'h2, 32'h0, "order after reset");
      $display("test reset done");
   endtask
   // Eight-bit count in bit mode; counters written only while idle
   task automatic t_order(input logic [7:0] ctl, input logic [7:0] ser, input logic [7:0] word);
      wr(OFF_DATA, 8'hC1);
      wr(OFF_WIDTH, 8'h00);
      wr(OFF_CNT_LOWER, 8'h01);
      wr(OFF_INT_MASK, 8'h01);
      wr(OFF_CONTROL, ctl);
      rd(OFF_STATUS, 32'h1, 32'h1, "busy before");
      spi_link_master_inst.select(1'b1);
      spi_link_master_inst.bits(16'h000F, 8, rx);
      chk({24'h0, rx[7:0]}, {24'h0, ser}, "serial order");
      rd(OFF_STATUS, 32'h1, 32'h0, "busy after");
      rd(OFF_DATA, 32'hFF, {24'h0, word}, "received word");
      rd(OFF_INT_STAT, 32'h1, 32'h1, "zero flag");
      chk({31'h0, irq}, 32'h1, "irq raised");
      wr(OFF_INT_MASK, 8'h00);
      rd(OFF_INT_MASK, 32'hFF, 32'h0, "mask off");
      chk({31'h0, irq}, 32'h0, "irq masked");
      wr(OFF_INT_MASK, 8'h01);
      wr(OFF_INT_STAT, 8'h03);
      rd(OFF_INT_STAT, 32'h3, 32'h0, "flags cleared");
      chk({31'h0, irq}, 32'h0, "irq cleared");
      spi_link_master_inst.select(1'b0);
      $display("test order %h done", ctl);
   endtask
   // Counter of upper, zero lower and, in bit mode, width ends one step after n
   task automatic t_count(input logic [7:0] ctl, input logic [7:0] w, input int n);
      wr(OFF_CONTROL, ctl);
      wr(OFF_WIDTH, w);
      wr(OFF_CNT_UPPER, 8'h01);
      spi_link_master_inst.select(1'b1);
      spi_link_master_inst.bits(16'hA5A5, n, rx);
      rd(OFF_STATUS, 32'h1, 32'h1, "busy before last");
      rd(OFF_INT_STAT, 32'h1, 32'h0, "no early zero");
      spi_link_master_inst.bits(16'h0001, 1, rx);
      rd(OFF_STATUS, 32'h1, 32'h0, "busy at zero");
      rd(OFF_INT_STAT, 32'h1, 32'h1, "zero reached");
      wr(OFF_INT_STAT, 8'h03);
      spi_link_master_inst.select(1'b0);
      $display("test count %0d done", n);
   endtask
   // Every width code in byte mode, one word each
   task automatic t_codes();
      int len;
      for (int c = 0; c < 8; c++) begin
         len = (c == 0) ? 8 : c;
         wr(OFF_WIDTH, 8'(c));
         wr(OFF_CNT_UPPER, 8'h00);
         wr(OFF_CNT_LOWER, 8'h01);
         spi_link_master_inst.select(1'b1);
         spi_link_master_inst.bits(16'h0001, len, rx);
         rd(OFF_STATUS, 32'h1, 32'h0, "word length count");
         rd(OFF_DATA, 32'hFF, 32'h1 << (len - 1), "short word");
         spi_link_master_inst.select(1'b0);
      end
      $display("test codes done");
   endtask
   initial begin
      nrst = 1'b0;
      avs_address = '0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = '0;
      avs_byteenable = 4'hF;
      fail_count = 0;
      compares = 0;
      repeat (8) @(posedge mclk);
      nrst <= 1'b1;
      t_regs();
      t_reset();
      t_order(8'h01, 8'h83, 8'hF0);
      t_order(8'h03, 8'hC1, 8'h0F);
      t_count(8'h01, 8'h03, 2050);
      t_count(8'h05, 8'h01, 255);
      t_codes();
      summarize();
   end
endmodule
`default_nettype wire
